// *** split_timer_regs.vh ***
`ifndef SPLIT_TIMER_REGS_VH
`define SPLIT_TIMER_REGS_VH

// ----------------------------------------------------------------------------
// register word indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define ST_IDX_CTRL 3'h0
`define ST_IDX_CNT_L 3'h1
`define ST_IDX_CNT_H 3'h2
`define ST_IDX_RLD_L 3'h3
`define ST_IDX_RLD_H 3'h4
`define ST_IDX_CKSEL 3'h5
`define ST_IDX_IEN 3'h6

// ----------------------------------------------------------------------------
// timer_control_reg fields
// ----------------------------------------------------------------------------
`define ST_CTRL_HFLAG 7
`define ST_CTRL_LFLAG 6
`define ST_CTRL_LIEN 5
`define ST_CTRL_CAPEN 4
`define ST_CTRL_SPLIT 3
`define ST_CTRL_RUN 2
`define ST_CTRL_XSEL_HI 1
`define ST_CTRL_XSEL_LO 0

// ----------------------------------------------------------------------------
// clock_select_reg and interrupt_enable_reg fields
// ----------------------------------------------------------------------------
`define ST_CKSEL_FAST_L 4
`define ST_CKSEL_FAST_H 5
`define ST_IEN_TIMER 5

// ----------------------------------------------------------------------------
// external clock select codes
// ----------------------------------------------------------------------------
`define ST_XSEL_DIV12 2'h0
`define ST_XSEL_RTC8 2'h1
`define ST_XSEL_RSVD 2'h2
`define ST_XSEL_CMP 2'h3

// ----------------------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------------------
`define ST_RST_BYTE 8'h00
`define ST_SYS_DIV 12
`define ST_RTC_DIV 8

`endif

// *** edge_sync.v ***
`timescale 1ns/1ps
`default_nettype none

module edge_sync (
   // clock and reset
   input wire mclk,
   input wire nrst,
   // asynchronous level in
   input wire async_i,
   // synchronised rising edge out
   output wire rise_o
);

   reg meta_q;
   reg sync_q;
   reg last_q;

   // meta_q feeds sync_q only; the edge is taken after the second stage
   always @(posedge mclk) begin
      if (!nrst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign rise_o = sync_q & ~last_q;

endmodule

`default_nettype wire

// *** split_timer.v ***
`timescale 1ns/1ps
`default_nettype none
`include "split_timer_regs.vh"

//
// Overview of operation
// - count is low half plus high half
// - split bit selects 16-bit or dual 8-bit
// - 16-bit wrap loads reload, sets high flag
// - timer irq enable fires on full overflow
// - low irq enable adds low-byte wrap interrupts
// - split halves reload from own reload byte
// - split: run gates high half only
// - fast bit picks system clock, else select field
// - rtc and comparator synchronised before use
// - split: each half wrap sets its flag
// - split: high always, low if enabled, interrupts
// - flags cleared only by software
// - capture enable bit turns on capture
// - capture on comparator rise or rtc/8
// - capture copies count to reload, sets flag
// - control register layout, all bits reset zero
// - low wrap sets low flag in every mode
//

module split_timer #(
   parameter SYS_DIV = `ST_SYS_DIV,
   parameter RTC_DIV = `ST_RTC_DIV
) (
   // clock and reset
   input wire mclk,
   input wire nrst,
   // wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [4:2] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   // external clock sources
   input wire rtc_clock,
   input wire cmp_out,
   // interrupt request
   output reg irq_o
);

   // ------------------------------------------------------------------------
   // derived constants
   // ------------------------------------------------------------------------
   // the divider end points are cut to the counter widths on purpose
   localparam [31:0] SYS_LAST_W = SYS_DIV - 1;
   localparam [31:0] RTC_LAST_W = RTC_DIV - 1;
   localparam [3:0] SYS_LAST = SYS_LAST_W[3:0];
   localparam [2:0] RTC_LAST = RTC_LAST_W[2:0];

   // ------------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------------
   reg [7:0] timer_control_reg_q;
   reg [7:0] timer_control_reg_d;
   reg [7:0] count_low_half_q;
   reg [7:0] count_low_half_d;
   reg [7:0] count_high_half_q;
   reg [7:0] count_high_half_d;
   reg [7:0] reload_low_half_q;
   reg [7:0] reload_low_half_d;
   reg [7:0] reload_high_half_q;
   reg [7:0] reload_high_half_d;
   reg [7:0] clock_select_reg_q;
   reg [7:0] interrupt_enable_reg_q;
   reg [3:0] div12_q;
   reg [2:0] rtc_div_q;
   reg [7:0] rd_byte;

   // ------------------------------------------------------------------------
   // field decode
   // ------------------------------------------------------------------------
   wire split_select = timer_control_reg_q[`ST_CTRL_SPLIT];
   wire run_control = timer_control_reg_q[`ST_CTRL_RUN];
   wire capture_enable = timer_control_reg_q[`ST_CTRL_CAPEN];
   wire low_overflow_irq_enable = timer_control_reg_q[`ST_CTRL_LIEN];
   wire high_overflow_flag = timer_control_reg_q[`ST_CTRL_HFLAG];
   wire low_overflow_flag = timer_control_reg_q[`ST_CTRL_LFLAG];
   wire [1:0] external_clock_select =
      timer_control_reg_q[`ST_CTRL_XSEL_HI:`ST_CTRL_XSEL_LO];
   wire external_select_bit1 = timer_control_reg_q[`ST_CTRL_XSEL_HI];
   wire low_half_fast_clock = clock_select_reg_q[`ST_CKSEL_FAST_L];
   wire high_half_fast_clock = clock_select_reg_q[`ST_CKSEL_FAST_H];
   wire timer_irq_enable = interrupt_enable_reg_q[`ST_IEN_TIMER];

   // ------------------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------------------
   // one word index compare, shared by every write strobe
   function idx_hit;
      input [2:0] a;
      input [2:0] idx;
      begin
         idx_hit = (a == idx);
      end
   endfunction

   // the access is taken once, on the edge at which ack rises
   wire req = cyc_i & stb_i & ~ack_o;
   // only byte lane 0 carries a register; upper lanes are dropped on write
   wire wr = req & we_i & sel_i[0];
   wire wr_ctrl = wr & idx_hit(adr_i, `ST_IDX_CTRL);
   wire wr_cnt_l = wr & idx_hit(adr_i, `ST_IDX_CNT_L);
   wire wr_cnt_h = wr & idx_hit(adr_i, `ST_IDX_CNT_H);
   wire wr_rld_l = wr & idx_hit(adr_i, `ST_IDX_RLD_L);
   wire wr_rld_h = wr & idx_hit(adr_i, `ST_IDX_RLD_H);
   wire wr_cksel = wr & idx_hit(adr_i, `ST_IDX_CKSEL);
   wire wr_ien = wr & idx_hit(adr_i, `ST_IDX_IEN);
   wire [7:0] wbyte = dat_i[7:0];

   // ------------------------------------------------------------------------
   // slow clock sources
   // ------------------------------------------------------------------------
   // pin edges reach the counters three clocks late; a source faster
   // than about half of mclk can lose edges
   wire rtc_rise;
   wire cmp_rise;

   edge_sync u_rtc_sync (
      .mclk(mclk),
      .nrst(nrst),
      .async_i(rtc_clock),
      .rise_o(rtc_rise)
   );

   edge_sync u_cmp_sync (
      .mclk(mclk),
      .nrst(nrst),
      .async_i(cmp_out),
      .rise_o(cmp_rise)
   );

   wire div12_tick = (div12_q == SYS_LAST);
   wire rtc8_tick = rtc_rise & (rtc_div_q == RTC_LAST);

   always @(posedge mclk) begin
      if (!nrst) begin
         div12_q <= 4'h0;
         rtc_div_q <= 3'h0;
      end else begin
         div12_q <= div12_tick ? 4'h0 : div12_q + 4'h1;
         if (rtc_rise) begin
            rtc_div_q <= (rtc_div_q == RTC_LAST) ? 3'h0 : rtc_div_q + 3'h1;
         end
      end
   end

   // ------------------------------------------------------------------------
   // clock source selection
   // ------------------------------------------------------------------------
   // reserved select code gives no ticks, so the half simply holds
   // both halves share the select field; only the fast bits are per half
   function pick_tick;
      input fast;
      input [1:0] xsel;
      input t_div12;
      input t_rtc;
      input t_cmp;
      begin
         if (fast) begin
            pick_tick = 1'b1;
         end else begin
            case (xsel)
               `ST_XSEL_DIV12: pick_tick = t_div12;
               `ST_XSEL_RTC8: pick_tick = t_rtc;
               `ST_XSEL_CMP: pick_tick = t_cmp;
               `ST_XSEL_RSVD: pick_tick = 1'b0;
               default: pick_tick = 1'b0;
            endcase
         end
      end
   endfunction

   wire tick_l = pick_tick(low_half_fast_clock, external_clock_select,
                           div12_tick, rtc8_tick, cmp_rise);
   wire tick_h = pick_tick(high_half_fast_clock, external_clock_select,
                           div12_tick, rtc8_tick, cmp_rise);

   // ------------------------------------------------------------------------
   // counting
   // ------------------------------------------------------------------------
   // low half free-runs in split mode; in 16-bit mode the high half is
   // carried by the low wrap and uses no tick of its own
   // in 16-bit mode a low wrap reloads only together with a high wrap
   wire adv_l = split_select ? tick_l : (run_control & tick_l);
   wire low_full = (count_low_half_q == 8'hFF);
   wire high_full = (count_high_half_q == 8'hFF);
   wire wrap_l = adv_l & low_full;
   wire adv_h = split_select ? (run_control & tick_h) : wrap_l;
   wire wrap_h = adv_h & high_full;

   // ------------------------------------------------------------------------
   // capture
   // ------------------------------------------------------------------------
   // capture also works in split mode, but the pair then holds two byte counts
   wire cap_src = external_select_bit1 ? cmp_rise : rtc8_tick;
   wire cap_evt = capture_enable & cap_src;

   wire set_h = wrap_h | cap_evt;
   wire set_l = wrap_l;

   // ------------------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------------------
   always @* begin
      count_low_half_d = count_low_half_q;
      count_high_half_d = count_high_half_q;
      if (adv_l) begin
         if (!low_full) begin
            count_low_half_d = count_low_half_q + 8'h01;
         end else if (split_select || wrap_h) begin
            count_low_half_d = reload_low_half_q;
         end else begin
            count_low_half_d = 8'h00;
         end
      end
      if (adv_h) begin
         count_high_half_d = high_full ? reload_high_half_q
                                       : count_high_half_q + 8'h01;
      end
      // a software write overrides the count in the same edge
      if (wr_cnt_l) begin
         count_low_half_d = wbyte;
      end
      if (wr_cnt_h) begin
         count_high_half_d = wbyte;
      end
   end

   always @* begin
      reload_low_half_d = reload_low_half_q;
      reload_high_half_d = reload_high_half_q;
      if (cap_evt) begin
         reload_low_half_d = count_low_half_q;
         reload_high_half_d = count_high_half_q;
      end
      if (wr_rld_l) begin
         reload_low_half_d = wbyte;
      end
      if (wr_rld_h) begin
         reload_high_half_d = wbyte;
      end
   end

   // flags: a hardware set wins over a software clear in the same edge
   // writing 1 to a flag sets it, so software can raise the request itself
   always @* begin
      timer_control_reg_d = wr_ctrl ? wbyte : timer_control_reg_q;
      if (set_h) begin
         timer_control_reg_d[`ST_CTRL_HFLAG] = 1'b1;
      end
      if (set_l) begin
         timer_control_reg_d[`ST_CTRL_LFLAG] = 1'b1;
      end
   end

   // ------------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------------
   always @(posedge mclk) begin
      if (!nrst) begin
         timer_control_reg_q <= `ST_RST_BYTE;
         count_low_half_q <= `ST_RST_BYTE;
         count_high_half_q <= `ST_RST_BYTE;
         reload_low_half_q <= `ST_RST_BYTE;
         reload_high_half_q <= `ST_RST_BYTE;
         clock_select_reg_q <= `ST_RST_BYTE;
         interrupt_enable_reg_q <= `ST_RST_BYTE;
      end else begin
         timer_control_reg_q <= timer_control_reg_d;
         count_low_half_q <= count_low_half_d;
         count_high_half_q <= count_high_half_d;
         reload_low_half_q <= reload_low_half_d;
         reload_high_half_q <= reload_high_half_d;
         // clock and interrupt enable words are plain storage beyond their used bits
         if (wr_cksel) begin
            clock_select_reg_q <= wbyte;
         end
         if (wr_ien) begin
            interrupt_enable_reg_q <= wbyte;
         end
      end
   end

   // ------------------------------------------------------------------------
   // interrupt request
   // ------------------------------------------------------------------------
   // level request, held while a flag stands; the low flag only counts
   // when its own enable is set, so the handler must look at both flags
   // one clock behind the flag so that the request leaves from a register
   always @(posedge mclk) begin
      if (!nrst) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= timer_irq_enable & (high_overflow_flag
                  | (low_overflow_irq_enable & low_overflow_flag));
      end
   end

   // ------------------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------------------
   // the 16-bit count is read a byte at a time with no shadow latch,
   // so the high half may step between the two reads
   always @* begin
      case (adr_i)
         `ST_IDX_CTRL: rd_byte = timer_control_reg_q;
         `ST_IDX_CNT_L: rd_byte = count_low_half_q;
         `ST_IDX_CNT_H: rd_byte = count_high_half_q;
         `ST_IDX_RLD_L: rd_byte = reload_low_half_q;
         `ST_IDX_RLD_H: rd_byte = reload_high_half_q;
         `ST_IDX_CKSEL: rd_byte = clock_select_reg_q;
         `ST_IDX_IEN: rd_byte = interrupt_enable_reg_q;
         default: rd_byte = 8'h00;
      endcase
   end

   // ------------------------------------------------------------------------
   // bus answer
   // ------------------------------------------------------------------------
   // one wait state; unmapped words ack with zero and ignore writes
   // a held request is masked while ack is high, so ack lasts one cycle
   always @(posedge mclk) begin
      if (!nrst) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         ack_o <= req;
         if (req) begin
            dat_o <= {24'h000000, rd_byte};
         end
      end
   end

endmodule

`default_nettype wire

// *** split_timer_sva.sv ***
`timescale 1ns/1ps
`default_nettype none

module split_timer_sva #(
   parameter SYS_DIV = 12,
   parameter RTC_DIV = 8
) (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // wishbone
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [4:2] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // sources and interrupt
   input wire logic rtc_clock,
   input wire logic cmp_out,
   input wire logic irq_o
);
   // ----------------------------------------------------------------
   // bus and interrupt relations
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   property p_ack_next;
      cyc_i && stb_i && !ack_o |=> ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("request not answered");
   property p_ack_pulse;
      ack_o |=> !ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ack_cause;
      ack_o |-> $past(cyc_i && stb_i && !ack_o);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_hi_zero;
      ack_o |-> dat_o[31:8] == 24'h000000;
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("upper read lanes not zero");
   property p_unmapped;
      cyc_i && stb_i && !ack_o && !we_i && adr_i == 3'h7 |=> dat_o == 32'h00000000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_dat_hold;
      !(cyc_i && stb_i) |=> $stable(dat_o);
   endproperty
   a_dat_hold: assert property (p_dat_hold) else $error("read data moved while idle");
   // flags are only cleared by software, so a falling request follows a write
   property p_irq_fall;
      $fell(irq_o) && $past(nrst) |-> $past(ack_o && we_i);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a write");
   property p_reset_out;
      $rose(nrst) |-> !irq_o && !ack_o && dat_o == 32'h00000000;
   endproperty
   a_reset_out: assert property (p_reset_out) else $error("outputs not idle after reset");
endmodule

bind split_timer split_timer_sva #(.SYS_DIV(SYS_DIV), .RTC_DIV(RTC_DIV)) split_timer_sva_i (
   .mclk(mclk), .nrst(nrst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
   .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rtc_clock(rtc_clock),
   .cmp_out(cmp_out), .irq_o(irq_o));

`default_nettype wire

// *** split_timer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "split_timer_regs.vh"

module split_timer_tb;
   // ----------------------------------------------------------------
   // stimulus and bus tasks
   // ----------------------------------------------------------------
   localparam logic [2:0] ctl = `ST_IDX_CTRL;
   localparam logic [2:0] cl = `ST_IDX_CNT_L;
   localparam logic [2:0] ch = `ST_IDX_CNT_H;
   localparam logic [2:0] rl = `ST_IDX_RLD_L;
   localparam logic [2:0] rh = `ST_IDX_RLD_H;
   localparam logic [2:0] ck = `ST_IDX_CKSEL;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [4:2] adr_i = 3'h0;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic rtc_clock = 1'b0;
   logic cmp_out = 1'b0;
   logic [31:0] dat_o;
   logic ack_o;
   logic irq_o;
   logic [3:0] rc = 4'h0;
   logic [7:0] q;
   logic [7:0] xlo [4] = '{8'h13, 8'h09, 8'h00, 8'h05};
   logic [7:0] xhi [4] = '{8'h15, 8'h0B, 8'h00, 8'h05};
   int xw [4] = '{240, 800, 100, 0};
   int fails = 0;
   int checks = 0;
   int cycles = 0;

   split_timer split_timer_i (.mclk(mclk), .nrst(nrst), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .rtc_clock(rtc_clock), .cmp_out(cmp_out), .irq_o(irq_o));

   always #4 mclk = ~mclk;

   // slow source of ten system cycles, so eight rises take eighty cycles
   always @(posedge mclk) begin
      rc <= (rc == 4'h9) ? 4'h0 : rc + 4'h1;
      rtc_clock <= (rc < 4'h5);
   end

   task automatic xfer(input logic [2:0] a, input logic w, input logic [7:0] d);
      begin
         cyc_i <= 1'b1;
         stb_i <= 1'b1;
         we_i <= w;
         adr_i <= a;
         sel_i <= 4'hF;
         dat_i <= {24'h000000, d};
         do begin
            @(posedge mclk);
         end while (ack_o !== 1'b1);
         q = dat_o[7:0];
         cyc_i <= 1'b0;
         stb_i <= 1'b0;
         we_i <= 1'b0;
         @(posedge mclk);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      xfer(a, 1'b1, d);
   endtask

   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
      xfer(a, 1'b0, 8'h00);
      cmp8(q & m, e);
   endtask

   task automatic rdr(input logic [2:0] a, input logic [7:0] lo, input logic [7:0] hi);
      xfer(a, 1'b0, 8'h00);
      checks++;
      if ((q >= lo && q <= hi) !== 1'b1) begin
         fails++;
         $display("[ERR] %0t got %h exp %h..%h", $time, q, lo, hi);
      end
   endtask

   task automatic irqc(input logic e);
      cmp8({7'h00, irq_o}, {7'h00, e});
   endtask

   task automatic pulse;
      cmp_out <= 1'b1;
      repeat (4) @(posedge mclk);
      cmp_out <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         $display("[ERR] %0t watchdog got %h exp %h", $time, cycles, 0);
         tally_and_finish();
      end
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      for (int i = 0; i < 8; i++) rdc(3'(i), 8'hFF, 8'h00);
      wr(3'h7, 8'hFF);
      rdc(3'h7, 8'hFF, 8'h00);
      for (int i = 1; i < 5; i++) begin
         wr(3'(i), 8'h5A + 8'(i));
         rdc(3'(i), 8'hFF, 8'h5A + 8'(i));
      end
      wr(ctl, 8'hE3);
      rdc(ctl, 8'hFF, 8'hE3);
      wr(`ST_IDX_IEN, 8'h20);
      irqc(1'b1);
      wr(ctl, 8'h00);
      irqc(1'b0);
      wr(ck, 8'h10);
      for (int l = 0; l < 2; l++) begin
         wr(ch, 8'h00);
         wr(cl, 8'hFC);
         wr(ctl, l ? 8'h24 : 8'h04);
         repeat (8) @(posedge mclk);
         rdc(ctl, 8'hC0, 8'h40);
         irqc(1'(l));
         rdc(ch, 8'hFF, 8'h01);
         wr(ctl, 8'h00);
         irqc(1'b0);
      end
      wr(rh, 8'h12);
      wr(rl, 8'h34);
      wr(ch, 8'hFF);
      wr(cl, 8'hF8);
      wr(ctl, 8'h04);
      repeat (40) @(posedge mclk);
      rdc(ctl, 8'h80, 8'h80);
      irqc(1'b1);
      rdc(ch, 8'hFF, 8'h12);
      wr(ctl, 8'h00);
      wr(ck, 8'h30);
      wr(rl, 8'hF0);
      wr(rh, 8'hA0);
      wr(ch, 8'hFE);
      wr(cl, 8'hFE);
      wr(ctl, 8'h08);
      repeat (20) @(posedge mclk);
      rdc(ch, 8'hFF, 8'hFE);
      rdr(cl, 8'hF0, 8'hFF);
      rdc(ctl, 8'hFF, 8'h48);
      irqc(1'b0);
      wr(ctl, 8'h4C);
      repeat (20) @(posedge mclk);
      rdc(ctl, 8'hC0, 8'hC0);
      rdr(ch, 8'hA0, 8'hBF);
      irqc(1'b1);
      wr(ctl, 8'h68);
      irqc(1'b1);
      wr(ctl, 8'h00);
      wr(ck, 8'h00);
      for (int x = 0; x < 4; x++) begin
         wr(cl, 8'h00);
         wr(ctl, 8'h04 | 8'(x));
         if (x == 3) repeat (5) pulse();
         else repeat (xw[x]) @(posedge mclk);
         wr(ctl, 8'h00);
         rdr(cl, xlo[x], xhi[x]);
      end
      wr(ck, 8'h10);
      wr(ctl, 8'h07);
      pulse();
      rdc(ctl, 8'h80, 8'h00);
      wr(ch, 8'h00);
      wr(cl, 8'h00);
      wr(ctl, 8'h17);
      repeat (100) @(posedge mclk);
      pulse();
      rdc(ctl, 8'h80, 8'h80);
      rdc(rh, 8'hFF, 8'h00);
      rdr(rl, 8'h64, 8'h78);
      wr(ctl, 8'h15);
      repeat (100) @(posedge mclk);
      rdc(ctl, 8'h80, 8'h80);
      irqc(1'b1);
      // reset in mid-run with a flag and the request standing
      nrst <= 1'b0;
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      irqc(1'b0);
      rdc(ctl, 8'hFF, 8'h00);
      rdc(rl, 8'hFF, 8'h00);
      rdc(`ST_IDX_IEN, 8'hFF, 8'h00);
      tally_and_finish();
   end
endmodule

`default_nettype wire
